//--- rtl/sedp_pkg.sv
// Constants, types and reset values for the soft ECC simple dual-port memory
package sedp_pkg;

  // ==========================================================================
  // Geometry
  localparam int DATA_W    = 64;  // User data per stored word
  localparam int HAM_W     = 7;   // Hamming check bits
  localparam int CHK_W     = 8;   // Hamming plus overall parity
  localparam int WORD_W    = DATA_W + CHK_W;
  localparam int ADDR_W    = 9;   // 512 stored words
  localparam int DEPTH     = 512;
  localparam int LANE_W    = 6;   // Up to 64 narrow items per word
  localparam int RD_ADDR_W = ADDR_W + LANE_W;

  // ==========================================================================
  // Field positions inside a stored word
  localparam int CHK_LSB   = DATA_W;  // Check bits sit above the data
  localparam int INJ_DBIT  = 0;       // Data bit flipped by injection
  localparam int INJ_CBIT  = 0;       // Check bit flipped by double injection

  // ==========================================================================
  // Read widths seen on the narrow side
  typedef enum logic [2:0] {
    SEDP_W1,
    SEDP_W2,
    SEDP_W4,
    SEDP_W8,
    SEDP_W16,
    SEDP_W32,
    SEDP_W64
  } sedp_width_t;

  // ==========================================================================
  // State of the top module apart from the storage array
  typedef struct packed {
    logic                 wr_go;     // Optional input stage
    logic [ADDR_W-1:0]    wr_addr;
    logic [DATA_W-1:0]    wr_data;
    logic                 inj_s;
    logic                 inj_d;
    logic                 rd_go;     // Memory read stage
    logic [WORD_W-1:0]    rd_word;
    logic [ADDR_W-1:0]    rd_addr;
    logic [LANE_W-1:0]    rd_lane;
    sedp_width_t          rd_width;
    logic                 s1_valid;  // Optional output stage
    logic [DATA_W-1:0]    s1_data;
    logic                 s1_sbe;
    logic                 s1_dbe;
    logic [ADDR_W-1:0]    s1_addr;
    logic                 o_valid;   // Output flops
    logic [DATA_W-1:0]    o_data;
    logic                 o_sbe;
    logic                 o_dbe;
    logic [ADDR_W-1:0]    o_addr;
  } sedp_state_t;

  localparam sedp_state_t SEDP_STATE_RST = '0;

  // Read latency in cycles from request to valid, without the out stage
  localparam int RD_LAT_BASE = 2;

endpackage : sedp_pkg

//--- rtl/sedp_codec.sv
// SECDED encoder and decoder for one 72-bit stored word of 64 data bits
`timescale 1ns/1ps
`default_nettype none
module sedp_codec
  import sedp_pkg::*;
(
  input  wire logic [sedp_pkg::DATA_W-1:0] enc_data,
  output logic      [sedp_pkg::CHK_W-1:0]  enc_check,
  input  wire logic [sedp_pkg::WORD_W-1:0] dec_word,
  output logic      [sedp_pkg::DATA_W-1:0] dec_data,
  output logic                             dec_sbe,
  output logic                             dec_dbe
);

  // Codeword position of a data bit, skipping power-of-two slots
  function automatic logic [6:0] data_pos(input int idx);
    int         cnt;
    logic [6:0] res;
    cnt = 0;
    res = '0;
    for (int p = 3; p < 128; p++)
    begin
      if ((p & (p - 1)) != 0)
      begin
        if (cnt == idx)
          res = 7'(p);
        cnt++;
      end
    end
    return res;
  endfunction

  // Whether data bit idx feeds Hamming check bit b
  function automatic logic feeds_check(input int idx, input int b);
    logic [6:0] pos;
    pos = data_pos(idx);
    return pos[b];
  endfunction

  // ==========================================================================
  // Encoder
  // seven Hamming bits plus overall parity
  always_comb
  begin
    enc_check = '0;
    for (int i = 0; i < DATA_W; i++)
      for (int b = 0; b < HAM_W; b++)
        if (feeds_check(i, b))
          enc_check[b] = enc_check[b] ^ enc_data[i];
    enc_check[CHK_W-1] = (^enc_data) ^ (^enc_check[HAM_W-1:0]);
  end

  // ==========================================================================
  // Decoder
  logic [HAM_W-1:0] syndrome;
  logic             parity_bad;

  // only a single error flips a data bit
  always_comb
  begin
    syndrome = dec_word[CHK_LSB +: HAM_W];
    for (int i = 0; i < DATA_W; i++)
      for (int b = 0; b < HAM_W; b++)
        if (feeds_check(i, b))
          syndrome[b] = syndrome[b] ^ dec_word[i];
    parity_bad = ^dec_word;
    dec_sbe    = parity_bad;
    dec_dbe    = !parity_bad && (syndrome != '0);
    dec_data   = dec_word[DATA_W-1:0];
    for (int i = 0; i < DATA_W; i++)
      if (dec_sbe && syndrome == data_pos(i))
        dec_data[i] = !dec_word[i];
  end

endmodule // sedp_codec
`default_nettype wire

//--- rtl/sedp_memory.sv
// Soft ECC simple dual-port memory: encode on write, correct on read
`timescale 1ns/1ps
`default_nettype none
module sedp_memory #(
  parameter bit REG_IN  = 1'b0,   // Extra write-side input stage
  parameter bit REG_OUT = 1'b0    // Extra read-side output stage
) (
  input  wire logic                           clk,
  input  wire logic                           rst_n,
  input  wire logic                           wr_en,
  input  wire logic [sedp_pkg::ADDR_W-1:0]    wr_addr,
  input  wire logic [sedp_pkg::DATA_W-1:0]    wr_data,
  input  wire logic                           inject_single_error,
  input  wire logic                           inject_double_error,
  input  wire logic                           rd_en,
  input  wire logic [sedp_pkg::RD_ADDR_W-1:0] rd_addr,
  input  wire sedp_pkg::sedp_width_t          rd_width,
  output logic                                read_valid,
  output logic      [sedp_pkg::DATA_W-1:0]    read_data,
  output logic                                single_error_flag,
  output logic                                double_error_flag,
  output logic      [sedp_pkg::ADDR_W-1:0]    error_read_address
);
  import sedp_pkg::*;

  localparam int RD_LAT = RD_LAT_BASE + (REG_OUT ? 1 : 0);

  // Log2 of a read width
  function automatic logic [2:0] width_log(input sedp_width_t w);
    return 3'(w);
  endfunction

  sedp_state_t       st;
  sedp_state_t       next_st;
  logic [WORD_W-1:0] mem [DEPTH];

  // ==========================================================================
  // Write side
  logic              w_go;
  logic [ADDR_W-1:0] w_addr;
  logic [DATA_W-1:0] w_data;
  logic              w_s;
  logic              w_d;
  logic [CHK_W-1:0]  w_check;
  logic [WORD_W-1:0] w_word;

  // Source is the input stage when enabled, else the ports
  // optional write-side stage
  always_comb
  begin
    w_go   = REG_IN ? st.wr_go   : wr_en;
    w_addr = REG_IN ? st.wr_addr : wr_addr;
    w_data = REG_IN ? st.wr_data : wr_data;
    w_s    = REG_IN ? st.inj_s   : inject_single_error;
    w_d    = REG_IN ? st.inj_d   : inject_double_error;
  end

  // Corrupt the encoded word on request
  // double injection wins over single
  // double flips a data bit and a check bit
  always_comb
  begin
    w_word = {w_check, w_data};
    if (w_d)
    begin
      w_word[INJ_DBIT]           = !w_word[INJ_DBIT];
      w_word[CHK_LSB + INJ_CBIT] = !w_word[CHK_LSB + INJ_CBIT];
    end
    else if (w_s)
      w_word[INJ_DBIT] = !w_word[INJ_DBIT];
  end

  // Storage array, read-before-write on a shared address
  // corruption stored with the word
  always_ff @(posedge clk)
  begin
    if (w_go)
      mem[w_addr] <= w_word;
  end

  // ==========================================================================
  // Codec
  logic [DATA_W-1:0] d_data;
  logic              d_sbe;
  logic              d_dbe;

  sedp_codec u_codec (
    .enc_data  (w_data),
    .enc_check (w_check),
    .dec_word  (st.rd_word),
    .dec_data  (d_data),
    .dec_sbe   (d_sbe),
    .dec_dbe   (d_dbe)
  );

  // ==========================================================================
  // Read side and narrow lane selection
  logic [2:0]          r_log;
  logic [RD_ADDR_W-1:0] r_word;
  logic [RD_ADDR_W-1:0] r_lane;
  logic [DATA_W-1:0]   lane_data;
  logic [DATA_W-1:0]   lane_mask;
  logic [2:0]          s_log;

  // Split the narrow address into word and lane
  // narrow read organisations
  always_comb
  begin
    r_log  = width_log(rd_width);
    r_word = rd_addr >> (3'd6 - r_log);
    r_lane = rd_addr & ((RD_ADDR_W'(1) << (3'd6 - r_log)) - RD_ADDR_W'(1));
    s_log  = width_log(st.rd_width);
    lane_mask = (s_log == 3'd6) ? '1 : ((DATA_W'(1) << (7'd1 << s_log)) - DATA_W'(1));
    lane_data = (d_data >> (st.rd_lane * (7'd1 << s_log))) & lane_mask;
  end

  // ==========================================================================
  // Next state
  always_comb
  begin
    next_st          = st;
    next_st.wr_go    = wr_en;
    next_st.wr_addr  = wr_addr;
    next_st.wr_data  = wr_data;
    next_st.inj_s    = inject_single_error;
    next_st.inj_d    = inject_double_error;
    next_st.rd_go    = rd_en;
    if (rd_en)
    begin
      next_st.rd_word  = mem[ADDR_W'(r_word)];
      next_st.rd_addr  = ADDR_W'(r_word);
      next_st.rd_lane  = LANE_W'(r_lane);
      next_st.rd_width = rd_width;
    end
    // Decoded result, through the extra stage when enabled
    // flags and address follow the decode
    next_st.s1_valid = st.rd_go;
    next_st.s1_data  = lane_data;
    next_st.s1_sbe   = st.rd_go && d_sbe;
    next_st.s1_dbe   = st.rd_go && d_dbe;
    next_st.s1_addr  = st.rd_addr;
    if (REG_OUT)
    begin
      next_st.o_valid = st.s1_valid;
      next_st.o_data  = st.s1_data;
      next_st.o_sbe   = st.s1_sbe;
      next_st.o_dbe   = st.s1_dbe;
      next_st.o_addr  = st.s1_addr;
    end
    else
    begin
      next_st.o_valid = next_st.s1_valid;
      next_st.o_data  = next_st.s1_data;
      next_st.o_sbe   = next_st.s1_sbe;
      next_st.o_dbe   = next_st.s1_dbe;
      next_st.o_addr  = next_st.s1_addr;
    end
  end

  // State register
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      st <= SEDP_STATE_RST;
    else
      st <= next_st;
  end

  // Outputs straight from flops
  assign read_valid         = st.o_valid;
  assign read_data          = st.o_data;
  assign single_error_flag  = st.o_sbe;
  assign double_error_flag  = st.o_dbe;
  assign error_read_address = st.o_addr;

  // ==========================================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence seq_dbl_write;
    w_go && w_d;
  endsequence

  sequence seq_sgl_write;
    w_go && w_s && !w_d;
  endsequence

  chk_flags_exclusive: assert property (!(single_error_flag && double_error_flag))
    else $error("both error flags high");

  chk_dbe_uncorrected: assert property (st.rd_go && d_dbe |-> d_data == st.rd_word[DATA_W-1:0])
    else $error("double error word was altered");

  chk_dbl_stored: assert property (seq_dbl_write |=>
    mem[$past(w_addr)][INJ_DBIT] != $past(w_data[INJ_DBIT])
    && mem[$past(w_addr)][CHK_LSB + INJ_CBIT] != $past(w_check[INJ_CBIT]))
    else $error("double injection not stored");

  chk_sgl_stored: assert property (seq_sgl_write |=>
    mem[$past(w_addr)][INJ_DBIT] != $past(w_data[INJ_DBIT])
    && mem[$past(w_addr)][CHK_LSB + INJ_CBIT] == $past(w_check[INJ_CBIT]))
    else $error("single injection not stored");

  chk_read_latency: assert property (rd_en |-> ##RD_LAT read_valid)
    else $error("read result late");

  chk_valid_cause: assert property (read_valid |-> $past(rd_en, RD_LAT))
    else $error("read result without request");

  chk_err_address: assert property ((single_error_flag || double_error_flag) |->
    error_read_address == ADDR_W'($past(rd_addr, RD_LAT) >> (3'd6 - width_log($past(rd_width, RD_LAT)))))
    else $error("error address mismatch");

  chk_width_mask: assert property (read_valid && $past(rd_width, RD_LAT) == SEDP_W8 |->
    read_data[DATA_W-1:8] == '0)
    else $error("narrow read leaks upper bits");

  chk_flag_with_valid: assert property ((single_error_flag || double_error_flag) |-> read_valid)
    else $error("error flag without read result");

endmodule // sedp_memory
`default_nettype wire

//--- verification/sedp_user_model.sv
// User logic model: drives both ports and notes each expected read result
`timescale 1ns/1ps
`default_nettype none
module sedp_user_model
  import sedp_pkg::*;
(
  input  wire logic                      clk,
  output logic                           wr_en,
  output logic [sedp_pkg::ADDR_W-1:0]    wr_addr,
  output logic [sedp_pkg::DATA_W-1:0]    wr_data,
  output logic                           inject_single_error,
  output logic                           inject_double_error,
  output logic                           rd_en,
  output logic [sedp_pkg::RD_ADDR_W-1:0] rd_addr,
  output sedp_pkg::sedp_width_t          rd_width
);
  typedef struct {
    logic [DATA_W-1:0] data;
    logic              sbe;
    logic              dbe;
    logic [ADDR_W-1:0] addr;
    int                due;
  } sedp_note_t;

  // ==========================================================================
  // Shadow contents, pending results, edge count
  logic [DATA_W-1:0] mem_data [DEPTH];
  logic [1:0]        mem_err  [DEPTH];
  sedp_note_t        notes    [$];
  sedp_note_t        notes_reg [$];  // Same results through both optional stages
  int                cyc = 0;

  // Count edges to time each result
  always @(posedge clk) cyc <= cyc + 1;

  // Quiet ports at time zero
  initial
  begin
    {wr_en, wr_addr, wr_data, inject_single_error, inject_double_error, rd_en, rd_addr} = '0;
    rd_width = SEDP_W64;
  end

  // One request cycle, driven at the falling edge
  task automatic put(input logic w, input logic r, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                     input logic si, input logic di, input logic [RD_ADDR_W-1:0] ra, input sedp_width_t wd);
    @(negedge clk);
    wr_en = w;
    wr_addr = a;
    wr_data = d;
    inject_single_error = si;
    inject_double_error = di;
    rd_en = r;
    rd_addr = ra;
    rd_width = wd;
  endtask

  // Idle cycle: released lines toggle, injection raised without a write
  task automatic idle;
    put(1'b0, 1'b0, ~wr_addr, ~wr_data, 1'b1, 1'b1, ~rd_addr, rd_width);
  endtask

  // Write a word, keeping what corruption was asked for
  task automatic write(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d, input logic si, input logic di);
    put(1'b1, 1'b0, a, d, si, di, ~rd_addr, rd_width);
    mem_data[a] = d;
    mem_err[a] = di ? 2'h2 : {1'b0, si};
  endtask

  // Read one lane; a double error leaves data bit 0 flipped
  task automatic read(input logic [ADDR_W-1:0] a, input sedp_width_t wd, input logic [LANE_W-1:0] lane);
    sedp_note_t        n;
    int                k;
    logic [LANE_W-1:0] l;
    logic [DATA_W-1:0] d;
    k = wd;
    l = lane & LANE_W'((1 << (LANE_W - k)) - 1);
    put(1'b0, 1'b1, ~wr_addr, ~wr_data, 1'b1, 1'b1, (RD_ADDR_W'(a) << (LANE_W - k)) | RD_ADDR_W'(l), wd);
    d = mem_data[a] ^ DATA_W'(mem_err[a][1]);
    n.data = (d >> (l * (1 << k))) & DATA_W'((65'h1 << (1 << k)) - 65'h1);
    n.sbe = mem_err[a] == 2'h1;
    n.dbe = mem_err[a][1];
    n.addr = a;
    n.due = cyc + RD_LAT_BASE;
    notes.push_back(n);
    n.due = cyc + RD_LAT_BASE + 1;  // One more edge through the output stage
    notes_reg.push_back(n);
  endtask
endmodule // sedp_user_model
`default_nettype wire

//--- verification/sedp_memory_test.sv
// Self-checking bench for the soft ECC simple dual-port memory
`timescale 1ns/1ps
`default_nettype none
module sedp_memory_test;
  import sedp_pkg::*;

  logic                 clk = 1'b0;
  logic                 rst_n = 1'b0;
  logic                 wr_en, inj_s, inj_d, rd_en;
  logic [ADDR_W-1:0]    wr_addr;
  logic [DATA_W-1:0]    wr_data;
  logic [RD_ADDR_W-1:0] rd_addr;
  sedp_width_t          rd_width;
  logic                 read_valid, single_error_flag, double_error_flag;
  logic [DATA_W-1:0]    read_data;
  logic [ADDR_W-1:0]    error_read_address;
  logic                 rv_reg, sbe_reg, dbe_reg;
  logic [DATA_W-1:0]    rd_reg;
  logic [ADDR_W-1:0]    ea_reg;
  int                   failures = 0;
  int                   comparisons = 0;
  int                   seed = 32'h1b32;
  int                   i;

  // ==========================================================================
  // Clock, design and user logic
  always #2 clk = ~clk;

  sedp_memory dut (.clk(clk), .rst_n(rst_n), .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data),
    .inject_single_error(inj_s), .inject_double_error(inj_d), .rd_en(rd_en), .rd_addr(rd_addr),
    .rd_width(rd_width), .read_valid(read_valid), .read_data(read_data), .single_error_flag(single_error_flag),
    .double_error_flag(double_error_flag), .error_read_address(error_read_address));

  sedp_user_model u_user (.clk(clk), .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data),
    .inject_single_error(inj_s), .inject_double_error(inj_d), .rd_en(rd_en), .rd_addr(rd_addr),
    .rd_width(rd_width));

  // Same traffic through a copy with both optional stages on
  sedp_memory #(.REG_IN(1'b1), .REG_OUT(1'b1)) dut_reg (.clk(clk), .rst_n(rst_n), .wr_en(wr_en),
    .wr_addr(wr_addr), .wr_data(wr_data), .inject_single_error(inj_s), .inject_double_error(inj_d),
    .rd_en(rd_en), .rd_addr(rd_addr), .rd_width(rd_width), .read_valid(rv_reg), .read_data(rd_reg),
    .single_error_flag(sbe_reg), .double_error_flag(dbe_reg), .error_read_address(ea_reg));

  // ==========================================================================
  // Compare helpers and closing
  task automatic cmp_word(input string nm, input logic [63:0] e, input logic [63:0] g);
    comparisons++;
    if (g !== e)
    begin
      $display("unexpected %s expected %h seen %h", nm, e, g);
      failures++;
    end
  endtask

  task automatic cmp_flag(input string nm, input logic e, input logic g);
    cmp_word(nm, {63'h0, e}, {63'h0, g});
  endtask

  task automatic end_sim;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Match each result against the oldest note
  always @(posedge clk)
  begin
    #1;
    if (read_valid !== 1'b0)
    begin
      if (u_user.notes.size() == 0)
        cmp_flag("read_valid", 1'b0, read_valid);
      else
      begin
        cmp_word("read_data", u_user.notes[0].data, read_data);
        cmp_flag("single_error_flag", u_user.notes[0].sbe, single_error_flag);
        cmp_flag("double_error_flag", u_user.notes[0].dbe, double_error_flag);
        cmp_word("error_read_address", 64'(u_user.notes[0].addr), 64'(error_read_address));
        cmp_word("latency", 64'(u_user.notes[0].due), 64'(u_user.cyc));
        void'(u_user.notes.pop_front());
      end
    end
  end

  // Same matching for the copy with both stages on
  always @(posedge clk)
  begin
    #1;
    if (rv_reg !== 1'b0)
    begin
      if (u_user.notes_reg.size() == 0)
        cmp_flag("reg read_valid", 1'b0, rv_reg);
      else
      begin
        cmp_word("reg read_data", u_user.notes_reg[0].data, rd_reg);
        cmp_flag("reg single_error_flag", u_user.notes_reg[0].sbe, sbe_reg);
        cmp_flag("reg double_error_flag", u_user.notes_reg[0].dbe, dbe_reg);
        cmp_word("reg error_read_address", 64'(u_user.notes_reg[0].addr), 64'(ea_reg));
        cmp_word("reg latency", 64'(u_user.notes_reg[0].due), 64'(u_user.cyc));
        void'(u_user.notes_reg.pop_front());
      end
    end
  end

  // Cut a hang short
  initial
  begin
    repeat (2000) @(posedge clk);
    failures++;
    end_sim;
  end

  // ==========================================================================
  // Scenarios
  initial
  begin
    repeat (16) @(negedge clk);
    rst_n = 1'b1;
    cmp_flag("read_valid", 1'b0, read_valid);
    cmp_flag("reg read_valid", 1'b0, rv_reg);
    // Every read width, random lanes, each read after its write and an idle cycle
    for (i = 0; i < 7; i++)
    begin
      u_user.write(9'(i * 73), {$random(seed), $random(seed)}, 1'b0, 1'b0);
      u_user.idle;  // Lets a staged write land before its read
      u_user.read(9'(i * 73), sedp_width_t'(i), 6'($random(seed)));
    end
    // Single, double, and both injections at once
    for (i = 1; i < 4; i++)
      u_user.write(9'(i), {$random(seed), $random(seed)}, i[0], i[1]);
    for (i = 1; i < 4; i++)
      u_user.read(9'(i), SEDP_W64, 6'h0);
    u_user.read(9'h003, SEDP_W1, 6'h0);
    u_user.write(9'h1ff, {$random(seed), $random(seed)}, 1'b1, 1'b0);
    u_user.idle;
    u_user.read(9'h1ff, SEDP_W32, 6'h1);
    // Second reset keeps stored words
    repeat (4) u_user.idle;
    rst_n = 1'b0;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    cmp_flag("read_valid", 1'b0, read_valid);
    cmp_flag("reg read_valid", 1'b0, rv_reg);
    u_user.read(9'h002, SEDP_W16, 6'($random(seed)));
    repeat (4) u_user.idle;
    cmp_word("pending", 64'h0, 64'(u_user.notes.size()));
    cmp_word("reg pending", 64'h0, 64'(u_user.notes_reg.size()));
    end_sim;
  end
endmodule // sedp_memory_test
`default_nettype wire
